// file: nsx_pkg.sv
// Shared encodings, field positions and types for the execute slice.
// Assumes a 14-bit instruction word and an 8-bit data path.
package nsx_pkg;

    // ==================================================================
    // Widths
    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int DIRSEL_W = 3;

    // ==================================================================
    // Field positions
    localparam int DEST_BIT = 7;
    localparam int NIB_LO_MSB = 3;
    localparam int NIB_HI_LSB = 4;
    localparam int NIB_W = 4;
    localparam int OPC_MSB = 13;
    localparam int OPC_LSB = 8;
    localparam int DIR_OPC_LSB = 3;

    // ==================================================================
    // Opcode patterns
    localparam logic [5:0] OPC_NIBBLE_EXCHANGE = 6'h0E;
    localparam logic [5:0] OPC_XOR_FILE = 6'h06;
    localparam logic [5:0] OPC_XOR_LITERAL = 6'h3A;
    localparam logic [10:0] OPC_DIRECTION_LOAD = 11'h00C;
    localparam logic [DIRSEL_W-1:0] DIR_SEL_MIN = 3'h5;
    localparam logic [DIRSEL_W-1:0] DIR_SEL_MAX = 3'h7;

    // ==================================================================
    // Reset values
    localparam logic [DATA_W-1:0] WREG_RST = 8'h00;
    localparam logic [DATA_W-1:0] DIR_RST = 8'hFF;
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

    typedef enum logic [2:0] {
        NSX_OP_NONE,
        NSX_OP_NIBBLE_EXCHANGE,
        NSX_OP_XOR_LITERAL,
        NSX_OP_XOR_FILE,
        NSX_OP_DIRECTION_LOAD
    } nsx_op_e;

    typedef struct packed {
        logic we;
        logic [FADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } nsx_fwr_s;

    typedef struct packed {
        logic we;
        logic [DIRSEL_W-1:0] sel;
        logic [DATA_W-1:0] data;
    } nsx_dwr_s;

endpackage : nsx_pkg

// file: nsx_exec.sv
// Execution of nibble exchange, two exclusive-OR forms and direction load.
// Assumes one instruction word per mclk and that the register file
// returns the addressed file value combinationally on file_rdata.
`timescale 1ns/1ps

// Contract
// - Nibble exchange swaps bits 3:0 and 7:4 of the addressed file value.
// - Nibble exchange writes W when d is 0, the file register when 1.
// - Literal XOR puts W xor k into W and updates only zero flag.
// - File XOR updates zero flag; result to W if d=0, file if d=1.
// - Direction load copies W to selector 5..7, no flags, one cycle.
module nsx_exec
    import nsx_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic instr_valid,
    input wire logic [INSTR_W-1:0] instr,
    input wire logic [DATA_W-1:0] file_rdata,
    output logic [FADDR_W-1:0] file_raddr,
    output nsx_fwr_s file_wr,
    output nsx_dwr_s dir_wr,
    output logic [DATA_W-1:0] wreg,
    output logic zero_flag,
    output logic zero_we
);

    // ==================================================================
    // Decode
    nsx_op_e op;
    logic dest_file;
    logic [DATA_W-1:0] result;

    always_comb begin
        op = NSX_OP_NONE;
        if (instr_valid) begin
            if (instr[OPC_MSB:OPC_LSB] == OPC_NIBBLE_EXCHANGE) begin
                op = NSX_OP_NIBBLE_EXCHANGE;
            end else if (instr[OPC_MSB:OPC_LSB] == OPC_XOR_LITERAL) begin
                op = NSX_OP_XOR_LITERAL;
            end else if (instr[OPC_MSB:OPC_LSB] == OPC_XOR_FILE) begin
                op = NSX_OP_XOR_FILE;
            end else if (instr[OPC_MSB:DIR_OPC_LSB] == OPC_DIRECTION_LOAD
                         && instr[DIRSEL_W-1:0] >= DIR_SEL_MIN) begin
                op = NSX_OP_DIRECTION_LOAD;
            end
        end
    end

    assign dest_file = instr[DEST_BIT];
    assign file_raddr = instr[FADDR_W-1:0];

    // ==================================================================
    // Datapath
    always_comb begin
        result = DATA_ZERO;
        unique case (op)
            NSX_OP_NIBBLE_EXCHANGE: result = {file_rdata[NIB_LO_MSB:0],
                file_rdata[NIB_HI_LSB +: NIB_W]};
            NSX_OP_XOR_LITERAL: result = wreg ^ instr[DATA_W-1:0];
            NSX_OP_XOR_FILE: result = wreg ^ file_rdata;
            NSX_OP_DIRECTION_LOAD: result = wreg;
            NSX_OP_NONE: result = DATA_ZERO;
        endcase
    end

    // ==================================================================
    // Write-back
    // Results are registered so every output except file_raddr comes from a flip-flop; the
    // file and direction writes therefore land one edge after decode.
    logic [DATA_W-1:0] next_wreg;
    logic next_zero_flag;
    logic next_zero_we;
    nsx_fwr_s next_file_wr;
    nsx_dwr_s next_dir_wr;

    always_comb begin
        next_wreg = wreg;
        next_zero_flag = zero_flag;
        next_zero_we = 1'b0;
        next_file_wr = '{we: 1'b0, addr: file_raddr, data: result};
        next_dir_wr = '{we: 1'b0, sel: instr[DIRSEL_W-1:0], data: result};
        unique case (op)
            NSX_OP_NIBBLE_EXCHANGE: begin
                if (dest_file) begin
                    next_file_wr.we = 1'b1;
                end else begin
                    next_wreg = result;
                end
            end
            NSX_OP_XOR_LITERAL: begin
                next_wreg = result;
                next_zero_flag = (result == DATA_ZERO);
                next_zero_we = 1'b1;
            end
            NSX_OP_XOR_FILE: begin
                if (dest_file) begin
                    next_file_wr.we = 1'b1;
                end else begin
                    next_wreg = result;
                end
                next_zero_flag = (result == DATA_ZERO);
                next_zero_we = 1'b1;
            end
            NSX_OP_DIRECTION_LOAD: begin
                next_dir_wr.we = 1'b1;
            end
            NSX_OP_NONE: begin
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wreg <= WREG_RST;
            zero_flag <= 1'b0;
            zero_we <= 1'b0;
            file_wr <= '0;
            dir_wr <= '0;
        end else begin
            wreg <= next_wreg;
            zero_flag <= next_zero_flag;
            zero_we <= next_zero_we;
            file_wr <= next_file_wr;
            dir_wr <= next_dir_wr;
        end
    end

    // ==================================================================
    // Checks
    sequence s_swap_to_file;
        op == NSX_OP_NIBBLE_EXCHANGE && dest_file;
    endsequence

    property p_swap_file;
        @(posedge mclk) disable iff (!rst_b)
        s_swap_to_file |=> file_wr.we && file_wr.data ==
            {$past(file_rdata[NIB_LO_MSB:0]),
            $past(file_rdata[NIB_HI_LSB +: NIB_W])};
    endproperty
    a_swap_file: assert property (p_swap_file)
        else $error("Swapped byte not written to file.");

    property p_swap_w;
        @(posedge mclk) disable iff (!rst_b)
        op == NSX_OP_NIBBLE_EXCHANGE && !dest_file |=> !file_wr.we
            && wreg == {$past(file_rdata[NIB_LO_MSB:0]),
            $past(file_rdata[NIB_HI_LSB +: NIB_W])};
    endproperty
    a_swap_w: assert property (p_swap_w)
        else $error("Swapped byte not written to W.");

    property p_swap_noflag;
        @(posedge mclk) disable iff (!rst_b)
        op == NSX_OP_NIBBLE_EXCHANGE |=> !zero_we && $stable(zero_flag);
    endproperty
    a_swap_noflag: assert property (p_swap_noflag)
        else $error("Nibble exchange touched the zero flag.");

    property p_xor_literal_op;
        @(posedge mclk) disable iff (!rst_b)
        op == NSX_OP_XOR_LITERAL |=> wreg == ($past(wreg)
            ^ $past(instr[DATA_W-1:0]))
            && zero_we && !file_wr.we && !dir_wr.we;
    endproperty
    a_xor_literal_op: assert property (p_xor_literal_op)
        else $error("Literal XOR result wrong.");

    property p_xor_file_op;
        @(posedge mclk) disable iff (!rst_b)
        op == NSX_OP_XOR_FILE && dest_file |=> file_wr.we
            && file_wr.data == ($past(wreg) ^ $past(file_rdata))
            && wreg == $past(wreg);
    endproperty
    a_xor_file_op: assert property (p_xor_file_op)
        else $error("File XOR result not written to file.");

    property p_dirload;
        @(posedge mclk) disable iff (!rst_b)
        op == NSX_OP_DIRECTION_LOAD |=> dir_wr.we
            && dir_wr.data == $past(wreg) && !zero_we ##1 !dir_wr.we
            || $past(op == NSX_OP_DIRECTION_LOAD);
    endproperty
    a_dirload: assert property (p_dirload)
        else $error("Direction load wrong.");

    property p_dir_range;
        @(posedge mclk) disable iff (!rst_b)
        dir_wr.we |-> dir_wr.sel >= DIR_SEL_MIN;
    endproperty
    a_dir_range: assert property (p_dir_range)
        else $error("Direction load outside selector range.");

    property p_zero;
        @(posedge mclk) disable iff (!rst_b)
        zero_we |-> zero_flag
            == ((file_wr.we ? file_wr.data : wreg) == DATA_ZERO);
    endproperty
    a_zero: assert property (p_zero)
        else $error("Zero flag disagrees with result.");

    property p_xor_file_op_w;
        @(posedge mclk) disable iff (!rst_b)
        op == NSX_OP_XOR_FILE && !dest_file |=> !file_wr.we
            && wreg == ($past(wreg) ^ $past(file_rdata)) && zero_we;
    endproperty
    a_xor_file_op_w: assert property (p_xor_file_op_w)
        else $error("File XOR result not written to W.");

    property p_dir_noflag;
        @(posedge mclk) disable iff (!rst_b)
        op == NSX_OP_DIRECTION_LOAD |=> !zero_we && $stable(zero_flag)
            && $stable(wreg) && !file_wr.we;
    endproperty
    a_dir_noflag: assert property (p_dir_noflag)
        else $error("Direction load disturbed W, flag or file.");

    // Checked on the raw word so that a decode fault cannot hide it.
    property p_dir_refused;
        @(posedge mclk) disable iff (!rst_b)
        instr_valid && instr[OPC_MSB:DIR_OPC_LSB] == OPC_DIRECTION_LOAD
            && instr[DIRSEL_W-1:0] < DIR_SEL_MIN |=> !dir_wr.we;
    endproperty
    a_dir_refused: assert property (p_dir_refused)
        else $error("Refused direction selector was loaded.");

    property p_zero_hold;
        @(posedge mclk) disable iff (!rst_b)
        !zero_we |-> zero_flag == $past(zero_flag);
    endproperty
    a_zero_hold: assert property (p_zero_hold)
        else $error("Zero flag moved without an update strobe.");

endmodule : nsx_exec

// file: tb_top.sv
// Self-checking bench for the nibble exchange and XOR execute slice.
// Assumes nsx_exec and nsx_pkg; bench plays the register file.
`timescale 1ns/1ps
module tb_top;
import nsx_pkg::*;
logic mclk = 1'b0;
logic rst_b = 1'b0;
logic instr_valid = 1'b0;
logic [INSTR_W-1:0] instr = 14'h0000;
logic [DATA_W-1:0] file_rdata = 8'h00;
logic [FADDR_W-1:0] file_raddr;
nsx_fwr_s file_wr;
nsx_dwr_s dir_wr;
logic [DATA_W-1:0] wreg;
logic zero_flag;
logic zero_we;
int err_total = 0;
int compares = 0;
logic [DATA_W-1:0] w_exp = 8'h00;
logic [DIRSEL_W-1:0] s;

nsx_exec dut (.mclk(mclk), .rst_b(rst_b), .instr_valid(instr_valid),
    .instr(instr), .file_rdata(file_rdata), .file_raddr(file_raddr),
    .file_wr(file_wr), .dir_wr(dir_wr), .wreg(wreg),
    .zero_flag(zero_flag), .zero_we(zero_we));

initial begin
    forever #2.5 mclk = ~mclk;
end

// ==================================================================
// Shared tasks
task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
        err_total++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask : chk

// Sampling 1 ns after the edge lets the registered pulses settle.
task exec(input logic [13:0] op, input logic [7:0] f);
    @(negedge mclk);
    instr_valid = 1'b1;
    instr = op;
    file_rdata = f;
    @(posedge mclk);
    #1;
endtask : exec

task t_reset;
    @(negedge mclk);
    instr_valid = 1'b0;
    rst_b = 1'b0;
    repeat (12) @(negedge mclk);
    chk(16'(wreg), 16'(WREG_RST));
    chk(16'({zero_flag, zero_we}), 16'h0000);
    chk(16'(file_wr), 16'h0000);
    chk(16'(dir_wr), 16'h0000);
    rst_b = 1'b1;
    w_exp = WREG_RST;
    $display("test reset done");
endtask : t_reset

// ==================================================================
// Scenarios
task t_swap;
    exec(14'h0E85, 8'hA5);
    chk(16'(file_wr), {1'b1, 7'h05, 8'h5A});
    chk(16'(file_raddr), 16'h0005);
    chk(16'(wreg), 16'(w_exp));
    chk(16'(zero_we), 16'h0000);
    exec(14'h0E05, 8'h3C);
    w_exp = 8'hC3;
    chk(16'(wreg), 16'(w_exp));
    chk(16'(file_wr.we), 16'h0000);
    $display("test swap done");
endtask : t_swap

task t_xor_literal_op;
    exec(14'h3AC3, 8'h00);
    chk(16'(wreg), 16'h0000);
    chk(16'({zero_flag, zero_we}), 16'h0003);
    chk(16'(file_wr.we), 16'h0000);
    exec(14'h0E85, 8'h0F);
    chk(16'({zero_flag, zero_we}), 16'h0002);
    chk(16'(file_wr), {1'b1, 7'h05, 8'hF0});
    exec(14'h3AAF, 8'h00);
    w_exp = 8'hAF;
    chk(16'(wreg), 16'(w_exp));
    chk(16'({zero_flag, zero_we}), 16'h0001);
    $display("test xor literal done");
endtask : t_xor_literal_op

task t_xor_file_op;
    exec(14'h0685, 8'hAF);
    chk(16'(file_wr), {1'b1, 7'h05, 8'h00});
    chk(16'(wreg), 16'(w_exp));
    chk(16'({zero_flag, zero_we}), 16'h0003);
    exec(14'h0605, 8'hB5);
    w_exp = 8'h1A;
    chk(16'(wreg), 16'(w_exp));
    chk(16'({zero_flag, zero_we}), 16'h0001);
    chk(16'(file_wr.we), 16'h0000);
    $display("test xor file done");
endtask : t_xor_file_op

// Selector 4 must be refused; 5 to 7 load W and leave the flag alone.
// The flag is set first so that a stray clear would show.
task t_dir;
    exec(14'h0685, w_exp);
    chk(16'({zero_flag, zero_we}), 16'h0003);
    chk(16'(wreg), 16'(w_exp));
    for (int i = 4; i < 8; i++) begin
        s = 3'(i);
        exec(14'h0060 | 14'(s), 8'hFF);
        if (i > 4)
            chk(16'(dir_wr), {4'h0, 1'b1, s, w_exp});
        else
            chk(16'(dir_wr.we), 16'h0000);
        chk(16'({zero_flag, zero_we, file_wr.we}), 16'h0004);
        chk(16'(wreg), 16'(w_exp));
    end
    exec(14'h0000, 8'h00);
    chk(16'({dir_wr.we, file_wr.we, zero_we}), 16'h0000);
    chk(16'(wreg), 16'(w_exp));
    $display("test direction load done");
endtask : t_dir

// ==================================================================
// Run and verdict
task end_of_test;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
        $display("All tests passed");
    else
        $display("Some tests failed");
    $finish;
endtask : end_of_test

initial begin
    repeat (12) @(negedge mclk);
    rst_b = 1'b1;
    t_swap();
    t_xor_literal_op();
    t_xor_file_op();
    t_dir();
    t_reset();
    t_swap();
    end_of_test();
end
endmodule : tb_top
